// ===== hdl/bodm_core.sv
`timescale 1ns/1ps
//
// Contract
// [RULE1] I/O bit set forces chosen bit to one, flags kept, two cycles.
// [RULE2] I/O bit clear forces chosen bit to zero, flags kept, two cycles.
// [RULE3] Rotate left through carry, updates Z C N V, one cycle.
// [RULE4] Rotate right through carry, updates Z C N V, one cycle.
// [RULE5] Each status flag set or cleared alone by its own op, one cycle.
// [RULE6] Register bit copied into transfer flag only, one cycle.
// [RULE7] Transfer flag written into register bit, flags kept, one cycle.
// [RULE8] Post-increment load reads at pointer, then bumps pointer, two cycles.
// [RULE9] Pre-decrement load drops pointer first, reads new address, two cycles.
// [RULE10] Displacement load uses Y or Z plus offset, pointer kept, two cycles.
// [RULE11] Post-increment store writes at pointer, then bumps pointer, two cycles.
// [RULE12] Pre-decrement store drops pointer, then writes there, two cycles.
// [RULE13] Displacement store uses Y or Z plus offset, pointer kept, two cycles.
// [RULE14] Direct load fetches byte at absolute address, two cycles.
// [RULE15] Direct store writes byte at absolute address, two cycles.
// [RULE16] Code read fetches byte at Z, optional post-increment, three cycles.
// [RULE17] Far code read uses page byte above Z, increments combined value.
// [RULE18] Push writes source onto stack in two cycles, flags kept.
// [RULE19] Pop loads destination from stack in two cycles, flags kept.
// [RULE20] Shifts take one cycle, fill zero or sign, update Z C N V.
// [RULE21] Copies, immediate load, port in and out: one cycle, flags kept.
module bodm_core
  import bodm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire bodm_inst_t  instIn,
  input  wire logic        instValid,
  output logic             instReady,
  output logic             instDone,
  output logic [15:0]      dAddr,
  output logic             dRe,
  output logic             dWe,
  output logic [7:0]       dWdata,
  input  wire logic [7:0]  dRdata,
  output logic [5:0]       ioAddr,
  output logic             ioRe,
  output logic             ioWe,
  output logic [7:0]       ioWdata,
  input  wire logic [7:0]  ioRdata,
  output logic [23:0]      pAddr,
  output logic             pRe,
  input  wire logic [7:0]  pRdata,
  output logic [7:0]       statusFlags,
  input  wire logic [5:0]  busAddr,
  input  wire logic [7:0]  busWdata,
  input  wire logic        busWe,
  input  wire logic        busRe,
  output logic [7:0]       busRdata
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  regFile_q [32];
  logic [7:0]  regFile_d [32];
  logic [7:0]  flg_q, flg_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0]  page_q, page_d;
  bodm_state_t state_q, state_d;
  bodm_inst_t  cur_q, cur_d;
  logic        ready_q, ready_d;
  logic        done_q, done_d;
  logic        inPend_q, inPend_d;
  logic [4:0]  inDst_q, inDst_d;
  logic [15:0] dAddr_q, dAddr_d;
  logic        dRe_q, dRe_d, dWe_q, dWe_d;
  logic [7:0]  dWdata_q, dWdata_d;
  logic [5:0]  ioAddr_q, ioAddr_d;
  logic        ioRe_q, ioRe_d, ioWe_q, ioWe_d;
  logic [7:0]  ioWdata_q, ioWdata_d;
  logic [23:0] pAddr_q, pAddr_d;
  logic        pRe_q, pRe_d;
  logic [7:0]  busRdata_q, busRdata_d;

  logic        accept;
  logic [7:0]  opA, opB;
  logic [4:0]  ptrLo;
  logic [15:0] ptrVal, effAddr, ptrNew;
  logic [23:0] farNext;

  // A port read lands one cycle late; forward it so a back-to-back reader sees it
  function automatic logic [7:0] rdReg(input logic [4:0] idx);
    rdReg = (inPend_q && idx == inDst_q) ? ioRdata : regFile_q[idx];
  endfunction

  // Z C N V after a shift or rotate; other flags stay
  function automatic logic [7:0] shiftFlags(input logic [7:0] r, input logic c);
    shiftFlags = flg_q;
    shiftFlags[FLAG_C] = c;
    shiftFlags[FLAG_Z] = (r == 8'h00);
    shiftFlags[FLAG_N] = r[7];
    shiftFlags[FLAG_V] = r[7] ^ c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and pointer arithmetic
  assign accept = instValid && ready_q;
  assign opA    = rdReg(instIn.rd);
  assign opB    = rdReg(instIn.rr);
  assign ptrLo  = (instIn.ptrSel == PTR_X) ? PTR_X_LO :
                  (instIn.ptrSel == PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
  assign ptrVal = {rdReg(ptrLo | 5'h01), rdReg(ptrLo)};
  assign farNext = {page_q, rdReg(PTR_Z_LO | 5'h01), rdReg(PTR_Z_LO)} + ONE24;

  // Effective address and written-back pointer per mode
  always_comb
  begin
    effAddr = ptrVal;
    ptrNew  = ptrVal;
    case (instIn.mode)
      AM_POST_INC: ptrNew = ptrVal + ONE16;              // [RULE8] [RULE11]
      AM_PRE_DEC:  {effAddr, ptrNew} = {2{ptrVal - ONE16}}; // [RULE9] [RULE12]
      AM_DISP:     effAddr = ptrVal + {8'h00, instIn.imm}; // [RULE10] [RULE13]
      default:     ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution: next state of every architectural and port register
  always_comb
  begin
    regFile_d  = regFile_q;
    flg_d      = flg_q;
    sp_d       = sp_q;
    page_d     = page_q;
    state_d    = state_q;
    cur_d      = cur_q;
    ready_d    = ready_q;
    done_d     = 1'b0;
    inPend_d   = 1'b0;
    inDst_d    = inDst_q;
    dAddr_d    = dAddr_q;
    dRe_d      = 1'b0;
    dWe_d      = 1'b0;
    dWdata_d   = dWdata_q;
    ioAddr_d   = ioAddr_q;
    ioRe_d     = 1'b0;
    ioWe_d     = 1'b0;
    ioWdata_d  = ioWdata_q;
    pAddr_d    = pAddr_q;
    pRe_d      = 1'b0;
    busRdata_d = 8'h00;
    // Register bus reads; unmapped addresses answer zero
    if (busRe && busAddr <= BA_REG_LAST)
      busRdata_d = regFile_q[busAddr[4:0]];
    else if (busRe && busAddr == BA_STATUS)
      busRdata_d = flg_q;
    else if (busRe && busAddr == BA_SP_LO)
      busRdata_d = sp_q[7:0];
    else if (busRe && busAddr == BA_SP_HI)
      busRdata_d = sp_q[15:8];
    else if (busRe && busAddr == BA_PAGE)
      busRdata_d = page_q;
    else if (busRe && busAddr == BA_STATE)
      busRdata_d = {4'h0, ready_q, state_q};
    // Bus writes go first so a same-cycle instruction write overrides them
    if (busWe && busAddr <= BA_REG_LAST)
      regFile_d[busAddr[4:0]] = busWdata;
    else if (busWe && busAddr == BA_STATUS)
      flg_d = busWdata;
    else if (busWe && busAddr == BA_SP_LO)
      sp_d[7:0] = busWdata;
    else if (busWe && busAddr == BA_SP_HI)
      sp_d[15:8] = busWdata;
    else if (busWe && busAddr == BA_PAGE)
      page_d = busWdata;
    // Port read issued last cycle lands now
    if (inPend_q)
      regFile_d[inDst_q] = ioRdata;                      // [RULE21]
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          cur_d  = instIn;
          done_d = 1'b1;
          case (instIn.op)
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
            begin
              ioAddr_d = instIn.addr[5:0];               // [RULE1] [RULE2]
              ioRe_d   = 1'b1;
              state_d  = ST_FIN;
            end
            OP_SHIFT_LEFT:
            begin
              regFile_d[instIn.rd] = {opA[6:0], 1'b0};   // [RULE20]
              flg_d = shiftFlags({opA[6:0], 1'b0}, opA[7]);
            end
            OP_SHIFT_RIGHT:
            begin
              regFile_d[instIn.rd] = {1'b0, opA[7:1]};   // [RULE20]
              flg_d = shiftFlags({1'b0, opA[7:1]}, opA[0]);
            end
            OP_ARITH_SHR:
            begin
              regFile_d[instIn.rd] = {opA[7], opA[7:1]}; // [RULE20]
              flg_d = shiftFlags({opA[7], opA[7:1]}, opA[0]);
            end
            OP_ROT_LEFT_C:
            begin
              regFile_d[instIn.rd] = {opA[6:0], flg_q[FLAG_C]};  // [RULE3]
              flg_d = shiftFlags({opA[6:0], flg_q[FLAG_C]}, opA[7]);
            end
            OP_ROT_RIGHT_C:
            begin
              regFile_d[instIn.rd] = {flg_q[FLAG_C], opA[7:1]};  // [RULE4]
              flg_d = shiftFlags({flg_q[FLAG_C], opA[7:1]}, opA[0]);
            end
            OP_SWAP_NIBBLE:  regFile_d[instIn.rd] = {opA[3:0], opA[7:4]};
            OP_STATUS_SET:   flg_d[instIn.bitSel] = 1'b1;      // [RULE5]
            OP_STATUS_CLEAR: flg_d[instIn.bitSel] = 1'b0;      // [RULE5]
            OP_BIT_TO_T:     flg_d[FLAG_T] = opA[instIn.bitSel]; // [RULE6]
            OP_T_TO_BIT:     regFile_d[instIn.rd][instIn.bitSel] = flg_q[FLAG_T]; // [RULE7]
            OP_REG_COPY:     regFile_d[instIn.rd] = opB;          // [RULE21]
            OP_PAIR_COPY:
            begin
              regFile_d[{instIn.rd[4:1], 1'b0}] = rdReg({instIn.rr[4:1], 1'b0}); // [RULE21]
              regFile_d[{instIn.rd[4:1], 1'b1}] = rdReg({instIn.rr[4:1], 1'b1});
            end
            OP_LOAD_IMM:     regFile_d[instIn.rd] = instIn.imm;   // [RULE21]
            OP_IO_IN:
            begin
              ioAddr_d = instIn.addr[5:0];               // [RULE21]
              ioRe_d   = 1'b1;
              inPend_d = 1'b1;
              inDst_d  = instIn.rd;
            end
            OP_IO_OUT:
            begin
              ioAddr_d  = instIn.addr[5:0];              // [RULE21]
              ioWe_d    = 1'b1;
              ioWdata_d = opB;
            end
            OP_LOAD_IND, OP_STORE_IND, OP_LOAD_DIRECT, OP_STORE_DIRECT:
            begin
              // Direct forms use the instruction address and leave pointers alone
              dAddr_d  = instIn.addr;                    // [RULE14] [RULE15]
              dRe_d    = instIn.op inside {OP_LOAD_IND, OP_LOAD_DIRECT};
              dWe_d    = instIn.op inside {OP_STORE_IND, OP_STORE_DIRECT};
              dWdata_d = opB;
              state_d  = ST_FIN;
              if (instIn.op inside {OP_LOAD_IND, OP_STORE_IND})
              begin
                dAddr_d = effAddr;                       // [RULE8] [RULE9] [RULE10] [RULE13]
                {regFile_d[ptrLo | 5'h01], regFile_d[ptrLo]} = ptrNew; // [RULE11] [RULE12]
              end
            end
            OP_PUSH, OP_POP:
            begin
              // Stack grows down: push writes then drops, pop raises then reads
              dAddr_d  = (instIn.op == OP_PUSH) ? sp_q : sp_q + ONE16; // [RULE18] [RULE19]
              sp_d     = (instIn.op == OP_PUSH) ? sp_q - ONE16 : sp_q + ONE16;
              dRe_d    = (instIn.op == OP_POP);
              dWe_d    = (instIn.op == OP_PUSH);
              dWdata_d = opA;
              state_d  = ST_FIN;
            end
            OP_CODE_READ, OP_FAR_CODE_READ:
            begin
              // Plain reads see page zero; the far form puts the page byte on top
              pAddr_d = {(instIn.op == OP_FAR_CODE_READ) ? page_q : 8'h00,
                         rdReg(PTR_Z_LO | 5'h01), rdReg(PTR_Z_LO)};   // [RULE16] [RULE17]
              pRe_d   = 1'b1;
              if (instIn.mode == AM_POST_INC)
              begin
                {regFile_d[PTR_Z_LO | 5'h01], regFile_d[PTR_Z_LO]} = farNext[15:0]; // [RULE16]
                if (instIn.op == OP_FAR_CODE_READ)
                  page_d = farNext[23:16];               // [RULE17]
              end
              state_d = ST_CODE;
            end
            default: ;
          endcase
          // Multi-cycle ops hold off the next instruction until they finish
          if (state_d != ST_IDLE)
            {done_d, ready_d} = 2'b00;
        end
      end
      ST_CODE:
        state_d = ST_FIN;                                // Code memory is one cycle slower
      ST_FIN:
      begin
        case (cur_q.op)
          OP_IO_BIT_SET:
          begin
            ioWe_d    = 1'b1;
            ioWdata_d = ioRdata | (8'h01 << cur_q.bitSel);    // [RULE1]
          end
          OP_IO_BIT_CLEAR:
          begin
            ioWe_d    = 1'b1;
            ioWdata_d = ioRdata & ~(8'h01 << cur_q.bitSel);   // [RULE2]
          end
          OP_LOAD_IND, OP_LOAD_DIRECT, OP_POP:
            regFile_d[cur_q.rd] = dRdata;                // [RULE8] [RULE14] [RULE19]
          OP_CODE_READ, OP_FAR_CODE_READ:
            regFile_d[cur_q.rd] = pRdata;                // [RULE16] [RULE17]
          default: ;
        endcase
        done_d  = 1'b1;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
      begin
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers only
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      regFile_q  <= '{default: 8'h00};
      flg_q      <= FLG_RESET;
      sp_q       <= SP_RESET;
      page_q     <= 8'h00;
      state_q    <= ST_IDLE;
      cur_q      <= '0;
      ready_q    <= 1'b1;
      done_q     <= 1'b0;
      inPend_q   <= 1'b0;
      inDst_q    <= 5'h00;
      dAddr_q    <= 16'h0000;
      dRe_q      <= 1'b0;
      dWe_q      <= 1'b0;
      dWdata_q   <= 8'h00;
      ioAddr_q   <= 6'h00;
      ioRe_q     <= 1'b0;
      ioWe_q     <= 1'b0;
      ioWdata_q  <= 8'h00;
      pAddr_q    <= 24'h000000;
      pRe_q      <= 1'b0;
      busRdata_q <= 8'h00;
    end
    else
    begin
      regFile_q  <= regFile_d;
      flg_q      <= flg_d;
      sp_q       <= sp_d;
      page_q     <= page_d;
      state_q    <= state_d;
      cur_q      <= cur_d;
      ready_q    <= ready_d;
      done_q     <= done_d;
      inPend_q   <= inPend_d;
      inDst_q    <= inDst_d;
      dAddr_q    <= dAddr_d;
      dRe_q      <= dRe_d;
      dWe_q      <= dWe_d;
      dWdata_q   <= dWdata_d;
      ioAddr_q   <= ioAddr_d;
      ioRe_q     <= ioRe_d;
      ioWe_q     <= ioWe_d;
      ioWdata_q  <= ioWdata_d;
      pAddr_q    <= pAddr_d;
      pRe_q      <= pRe_d;
      busRdata_q <= busRdata_d;
    end
  end

  assign instReady   = ready_q;
  assign instDone    = done_q;
  assign dAddr       = dAddr_q;
  assign dRe         = dRe_q;
  assign dWe         = dWe_q;
  assign dWdata      = dWdata_q;
  assign ioAddr      = ioAddr_q;
  assign ioRe        = ioRe_q;
  assign ioWe        = ioWe_q;
  assign ioWdata     = ioWdata_q;
  assign pAddr       = pAddr_q;
  assign pRe         = pRe_q;
  assign statusFlags = flg_q;
  assign busRdata    = busRdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; all in the one clock domain, quiet while reset is held
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_io_set;
    accept && instIn.op == OP_IO_BIT_SET |=> ioRe_q && !ready_q ##1
      (ioWe_q && ioWdata_q[cur_q.bitSel] && $stable(flg_q) && ready_q);
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong"); // [RULE1]

  property p_io_clr;
    accept && instIn.op == OP_IO_BIT_CLEAR |=> ioRe_q ##1
      (ioWe_q && !ioWdata_q[cur_q.bitSel] && ready_q);
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong"); // [RULE2]

  property p_rotl;
    accept && instIn.op == OP_ROT_LEFT_C && !busWe && !inPend_q |=>
      regFile_q[cur_q.rd] == {$past(opA[6:0]), $past(flg_q[FLAG_C])} &&
      flg_q[FLAG_C] == $past(opA[7]) && ready_q;
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong"); // [RULE3]

  property p_status_set;
    accept && instIn.op == OP_STATUS_SET && !busWe |=>
      flg_q == ($past(flg_q) | (8'h01 << $past(instIn.bitSel)));
  endproperty
  a_status_set: assert property (p_status_set) else $error("flag set wrong"); // [RULE5]

  property p_bit_to_t;
    accept && instIn.op == OP_BIT_TO_T && !busWe |=>
      flg_q[FLAG_T] == $past(opA[instIn.bitSel]) &&
      (flg_q & 8'hbf) == ($past(flg_q) & 8'hbf);
  endproperty
  a_bit_to_t: assert property (p_bit_to_t) else $error("transfer flag wrong"); // [RULE6]

  property p_load_post_inc;
    accept && instIn.op == OP_LOAD_IND && instIn.mode == AM_POST_INC |=>
      dRe_q && dAddr_q == $past(ptrVal) && !ready_q ##1 ready_q && done_q;
  endproperty
  a_load_post_inc: assert property (p_load_post_inc) else $error("post-inc load wrong"); // [RULE8]

  property p_store_pre_dec;
    accept && instIn.op == OP_STORE_IND && instIn.mode == AM_PRE_DEC |=>
      dWe_q && dAddr_q == $past(ptrVal) - ONE16 ##1 ready_q;
  endproperty
  a_store_pre_dec: assert property (p_store_pre_dec) else $error("pre-dec store wrong"); // [RULE12]

  property p_code_read;
    accept && instIn.op == OP_CODE_READ |=> pRe_q && pAddr_q[23:16] == 8'h00 ##1
      !ready_q ##1 ready_q && done_q;
  endproperty
  a_code_read: assert property (p_code_read) else $error("code read timing wrong"); // [RULE16]

  property p_push;
    accept && instIn.op == OP_PUSH && !busWe |=>
      dWe_q && dAddr_q == $past(sp_q) && dWdata_q == $past(opA) && $stable(flg_q);
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // [RULE18]

endmodule

// ===== hdl/bodm_pkg.sv
package bodm_pkg;

  // Instruction groups executed by the core
  typedef enum logic [4:0] {
    OP_IO_BIT_SET    = 5'h00,
    OP_IO_BIT_CLEAR  = 5'h01,
    OP_SHIFT_LEFT    = 5'h02,
    OP_SHIFT_RIGHT   = 5'h03,
    OP_ROT_LEFT_C    = 5'h04,
    OP_ROT_RIGHT_C   = 5'h05,
    OP_ARITH_SHR     = 5'h06,
    OP_SWAP_NIBBLE   = 5'h07,
    OP_STATUS_SET    = 5'h08,
    OP_STATUS_CLEAR  = 5'h09,
    OP_BIT_TO_T      = 5'h0a,
    OP_T_TO_BIT      = 5'h0b,
    OP_REG_COPY      = 5'h0c,
    OP_PAIR_COPY     = 5'h0d,
    OP_LOAD_IMM      = 5'h0e,
    OP_IO_IN         = 5'h0f,
    OP_IO_OUT        = 5'h10,
    OP_LOAD_IND      = 5'h11,
    OP_STORE_IND     = 5'h12,
    OP_LOAD_DIRECT   = 5'h13,
    OP_STORE_DIRECT  = 5'h14,
    OP_CODE_READ     = 5'h15,
    OP_FAR_CODE_READ = 5'h16,
    OP_PUSH          = 5'h17,
    OP_POP           = 5'h18
  } bodm_op_t;

  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} bodm_ptr_t;
  typedef enum logic [1:0] {AM_PLAIN = 2'h0, AM_POST_INC = 2'h1, AM_PRE_DEC = 2'h2,
                            AM_DISP = 2'h3} bodm_mode_t;

  // One decoded instruction
  typedef struct packed {
    bodm_op_t   op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bitSel;
    bodm_ptr_t  ptrSel;
    bodm_mode_t mode;
    logic [7:0] imm;
    logic [15:0] addr;
  } bodm_inst_t;

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_FIN = 3'b010, ST_CODE = 3'b100} bodm_state_t;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_T = 6;

  // Pointer low-byte register indices
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  localparam logic [15:0] SP_RESET   = 16'h00ff;
  localparam logic [7:0]  FLG_RESET  = 8'h00;
  localparam logic [15:0] ONE16      = 16'h0001;
  localparam logic [23:0] ONE24      = 24'h000001;

  // Register bus map
  localparam logic [5:0] BA_REG_LAST = 6'h1f;
  localparam logic [5:0] BA_STATUS   = 6'h20;
  localparam logic [5:0] BA_SP_LO    = 6'h21;
  localparam logic [5:0] BA_SP_HI    = 6'h22;
  localparam logic [5:0] BA_PAGE     = 6'h23;
  localparam logic [5:0] BA_STATE    = 6'h24;

endpackage

// ===== verif/bodm_mem_model.sv
`timescale 1ns/1ps
module bodm_mem_model
(
  input  wire logic        clk,
  input  wire logic [15:0] dAddr,
  input  wire logic        dRe,
  input  wire logic        dWe,
  input  wire logic [7:0]  dWdata,
  output logic [7:0]       dRdata,
  input  wire logic [5:0]  ioAddr,
  input  wire logic        ioRe,
  input  wire logic        ioWe,
  input  wire logic [7:0]  ioWdata,
  output logic [7:0]       ioRdata,
  input  wire logic [23:0] pAddr,
  input  wire logic        pRe,
  output logic [7:0]       pRdata
);
  logic [7:0] dmem [65536];
  logic [7:0] io   [64];
  logic [7:0] junk  = 8'h00;
  logic [7:0] pByte = 8'h00;
  logic       pLive = 1'b0;

  // Code space is a fixed pattern so any byte can be predicted
  function automatic logic [7:0] codeByte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction

  // Address-derived contents, distinct per io location only
  initial
  begin
    for (int k = 0; k < 65536; k++)
      dmem[k] = k[7:0] ^ k[15:8] ^ 8'ha5;
    for (int k = 0; k < 64; k++)
      io[k] = k[7:0] ^ 8'h5a;
  end

  // Writes land on the edge; the pattern moves every cycle
  always @(posedge clk)
  begin
    junk  <= junk + 8'h35;
    pLive <= pRe;
    pByte <= codeByte(pAddr);
    if (dWe)
      dmem[dAddr] <= dWdata;
    if (ioWe)
      io[ioAddr] <= ioWdata;
  end

  // Unselected lines never repeat the last value
  assign dRdata  = dRe ? dmem[dAddr] : junk;
  assign ioRdata = ioRe ? io[ioAddr] : ~junk;
  assign pRdata  = pLive ? pByte : junk ^ 8'hc3;
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
  import bodm_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  bodm_inst_t  instIn = '0;
  logic        instValid = 1'b0;
  logic        instReady, instDone, dRe, dWe, ioRe, ioWe, pRe;
  logic [15:0] dAddr;
  logic [7:0]  dWdata, dRdata, ioWdata, ioRdata, pRdata, statusFlags, busRdata;
  logic [5:0]  ioAddr;
  logic [23:0] pAddr;
  logic [5:0]  busAddr = '0;
  logic [7:0]  busWdata = '0;
  logic        busWe = 1'b0;
  logic        busRe = 1'b0;
  logic [7:0]  r [32];
  logic [7:0]  fl = '0;
  logic [7:0]  pg = '0;
  logic [15:0] sp = 16'h00ff;
  int          failures = 0;
  int          testsRun = 0;
  integer      seed = 32'h44d7;

  bodm_core u_bodm_core (.clk, .resetn, .instIn, .instValid, .instReady, .instDone, .dAddr,
    .dRe, .dWe, .dWdata, .dRdata, .ioAddr, .ioRe, .ioWe, .ioWdata, .ioRdata, .pAddr, .pRe,
    .pRdata, .statusFlags, .busAddr, .busWdata, .busWe, .busRe, .busRdata);
  bodm_mem_model u_bodm_mem_model (.clk, .dAddr, .dRe, .dWe, .dWdata, .dRdata, .ioAddr,
    .ioRe, .ioWe, .ioWdata, .ioRdata, .pAddr, .pRe, .pRdata);

  // 100 MHz
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bus cycles; read data stand only in the cycle after the strobe
  task automatic busRead(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    busRe <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRe <= 1'b0;
    @(negedge clk);
    d = busRdata;
  endtask

  task automatic setLoc(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    {busWe, busAddr, busWdata} <= {1'b1, a, v};
    @(posedge clk);
    busWe <= 1'b0;
    if (a <= BA_REG_LAST)
      r[a[4:0]] = v;
    if (a == BA_STATUS)
      fl = v;
    if (a == BA_PAGE)
      pg = v;
  endtask

  task automatic setPtr(input logic [4:0] lo, input logic [15:0] v);
    setLoc({1'b0, lo + 5'h1}, v[15:8]);
    setLoc({1'b0, lo}, v[7:0]);
  endtask

  // Whole visible state; catches any side effect on other registers
  task automatic checkAll();
    logic [7:0] d;
    logic [5:0] ad [6] = '{BA_STATUS, BA_SP_LO, BA_SP_HI, BA_PAGE, BA_STATE, 6'h3f};
    logic [7:0] ex [6] = '{fl, sp[7:0], sp[15:8], pg, 8'h09, 8'h00};
    for (int k = 0; k < 32; k++)
    begin
      busRead(6'(k), d);
      check("reg", d, r[k]);
    end
    for (int k = 0; k < 6; k++)
    begin
      busRead(ad[k], d);
      check("ctl", d, ex[k]);
    end
    check("flagPort", statusFlags, fl);
  endtask

  function automatic bodm_inst_t mk(input bodm_op_t op, input logic [4:0] rd,
                                    input logic [2:0] b, input bodm_ptr_t p, input bodm_mode_t m);
    return '{op, rd, rd, b, p, m, 8'h05, 16'h0123};
  endfunction

  // Illegal pointer and mode combinations are steered away
  function automatic bodm_inst_t rndInst();
    bodm_inst_t i;
    i = 46'({$random(seed), $random(seed)});
    i.op = bodm_op_t'(5'($unsigned($random(seed)) % 25));
    if (i.op inside {OP_LOAD_IND, OP_STORE_IND, OP_CODE_READ, OP_FAR_CODE_READ})
      {i.rd[4], i.rr[4]} = 2'b00;
    if (i.op inside {OP_CODE_READ, OP_FAR_CODE_READ})
      i.mode = i.mode[0] ? AM_POST_INC : AM_PLAIN;
    if (i.mode == AM_DISP || i.ptrSel[1])
      i.ptrSel = i.ptrSel[0] ? PTR_Y : PTR_Z;
    return i;
  endfunction

  // Predict, issue, time the completion, then compare everything
  task automatic run(input bodm_inst_t i);
    logic [4:0]  lo;
    logic [15:0] p, q, a, z, da;
    logic [23:0] fz;
    logic [7:0]  v, o, iv, dv;
    logic [5:0]  ia;
    logic [1:0]  cyc;
    logic        sh, cc, dWant, ioWant;
    int          n;
    lo = i.ptrSel == PTR_X ? PTR_X_LO : i.ptrSel == PTR_Y ? PTR_Y_LO : PTR_Z_LO;
    p = {r[lo + 5'h1], r[lo]};
    q = i.mode == AM_PRE_DEC ? p - 16'h1 : i.mode == AM_POST_INC ? p + 16'h1 : p;
    a = i.mode == AM_DISP ? p + {8'h00, i.imm} : i.mode == AM_PRE_DEC ? q : p;
    z = {r[PTR_Z_LO + 5'h1], r[PTR_Z_LO]};
    fz = {pg, z} + (i.mode == AM_POST_INC ? ONE24 : 24'h0);
    {v, ia, cyc, sh, dWant, ioWant} = {r[i.rd], i.addr[5:0], 2'd1, 3'b000};
    o = v;
    case (i.op)
      OP_IO_BIT_SET: {ioWant, iv, cyc} = {1'b1, u_bodm_mem_model.io[ia] | 8'(1 << i.bitSel), 2'd2};
      OP_IO_BIT_CLEAR: {ioWant, iv, cyc} = {1'b1, u_bodm_mem_model.io[ia] & ~8'(1 << i.bitSel), 2'd2};
      OP_SHIFT_LEFT: {sh, cc, o} = {1'b1, v, 1'b0};
      OP_SHIFT_RIGHT: {sh, o, cc} = {1'b1, 1'b0, v};
      OP_ROT_LEFT_C: {sh, cc, o} = {1'b1, v, fl[FLAG_C]};
      OP_ROT_RIGHT_C: {sh, o, cc} = {1'b1, fl[FLAG_C], v};
      OP_ARITH_SHR: {sh, o, cc} = {1'b1, v[7], v};
      OP_SWAP_NIBBLE: o = {v[3:0], v[7:4]};
      OP_STATUS_SET: fl[i.bitSel] = 1'b1;
      OP_STATUS_CLEAR: fl[i.bitSel] = 1'b0;
      OP_BIT_TO_T: fl[FLAG_T] = r[i.rd][i.bitSel];
      OP_T_TO_BIT: o[i.bitSel] = fl[FLAG_T];
      OP_REG_COPY: o = r[i.rr];
      OP_PAIR_COPY: {r[{i.rd[4:1], 1'b1}], r[{i.rd[4:1], 1'b0}]} = {r[i.rr | 5'h1], r[i.rr & 5'h1e]};
      OP_LOAD_IMM: o = i.imm;
      OP_IO_IN: o = u_bodm_mem_model.io[ia];
      OP_IO_OUT: {ioWant, iv} = {1'b1, r[i.rr]};
      OP_LOAD_IND: {cyc, o, r[lo + 5'h1], r[lo]} = {2'd2, u_bodm_mem_model.dmem[a], q};
      OP_STORE_IND: {cyc, dWant, dv, da, r[lo + 5'h1], r[lo]} = {2'd2, 1'b1, r[i.rr], a, q};
      OP_LOAD_DIRECT: {cyc, o} = {2'd2, u_bodm_mem_model.dmem[i.addr]};
      OP_STORE_DIRECT: {cyc, dWant, dv, da} = {2'd2, 1'b1, r[i.rr], i.addr};
      OP_CODE_READ: {cyc, o, r[31], r[30]} = {2'd3, u_bodm_mem_model.codeByte({8'h0, z}), fz[15:0]};
      OP_FAR_CODE_READ: {cyc, o, pg, r[31], r[30]} = {2'd3, u_bodm_mem_model.codeByte({pg, z}), fz};
      OP_PUSH: {cyc, dWant, dv, da, sp} = {2'd2, 1'b1, r[i.rd], sp, sp - 16'h1};
      OP_POP: {cyc, o, sp} = {2'd2, u_bodm_mem_model.dmem[sp + 16'h1], sp + 16'h1};
      default: ;
    endcase
    if (sh)
      {fl[FLAG_V], fl[FLAG_N], fl[FLAG_Z], fl[FLAG_C]} = {o[7] ^ cc, o[7], o == 8'h00, cc};
    if (o !== v)
      r[i.rd] = o;
    @(posedge clk);
    instIn <= i;
    instValid <= 1'b1;
    @(posedge clk);
    instValid <= 1'b0;
    n = 1;
    @(negedge clk);
    while (instDone !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    check("cycles", 8'(n), {6'h00, cyc});
    checkAll();
    if (dWant)
      check("dmem", u_bodm_mem_model.dmem[da], dv);
    if (ioWant)
      check("io", u_bodm_mem_model.io[ia], iv);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset, corner cases first, then random traffic
  initial
  begin
    r = '{default: 8'h00};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    checkAll();
    for (int k = 0; k < 32; k++)
      setLoc(6'(k), 8'($random(seed)));
    setLoc(6'h3f, 8'hff);
    checkAll();
    $display("test reset and bus done");
    for (int b = 0; b < 16; b++)
      run(mk(b < 8 ? OP_STATUS_SET : OP_STATUS_CLEAR, 5'h0, 3'(b), PTR_X, AM_PLAIN));
    setLoc(BA_STATUS, 8'h01);
    setLoc(6'h10, 8'h80);
    run(mk(OP_ROT_LEFT_C, 5'h10, 3'h0, PTR_X, AM_PLAIN));
    run(mk(OP_ROT_RIGHT_C, 5'h10, 3'h0, PTR_X, AM_PLAIN));
    setPtr(PTR_X_LO, 16'hffff);
    run(mk(OP_LOAD_IND, 5'h3, 3'h0, PTR_X, AM_POST_INC));
    setPtr(PTR_Y_LO, 16'h0000);
    run(mk(OP_STORE_IND, 5'h4, 3'h0, PTR_Y, AM_PRE_DEC));
    setLoc(BA_PAGE, 8'h02);
    setPtr(PTR_Z_LO, 16'hffff);
    run(mk(OP_FAR_CODE_READ, 5'h5, 3'h0, PTR_Z, AM_POST_INC));
    setPtr(PTR_Z_LO, 16'hffff);
    run(mk(OP_CODE_READ, 5'h0, 3'h0, PTR_Z, AM_POST_INC));
    $display("test corners done");
    repeat (250) run(rndInst());
    $display("test random done");
    results();
  end

  // A hang is cut short well past the expected run length
  initial
  begin
    #1_000_000;
    failures++;
    results();
  end
endmodule
